// *** logic/spr_pkg.sv ***
// Constants shared by the serial port register set and its data FIFO
//
// How it works
// - Nine-bit modes load received ninth bit into flag
// - Control resets to zero, supports bit set/clear
// - Control at 98h with documented bit order
// - Address mask register at B9h, resets zero
// - Slave address register at A9h, resets zero
// - Data buffer at 99h, write sends, read receives
// - Framing detection sets error on invalid stop
// - Framing error sticky until software or reset
// - Framing detection moves receive flag to stop
// - Broadcast address is address OR mask
package spr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_SLAVE = 8'hA9;
  localparam logic [7:0] ADDR_MASK = 8'hB9;

  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int BIT_MODE0_ERR = 7;
  localparam int BIT_MODE1 = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_SLAVE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  // ****************************************************************
  // Port modes and transmit FIFO shape
  // ****************************************************************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;

endpackage

// *** logic/spr_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module spr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic inValid, // Source offers a word
  output logic inReady, // FIFO has room
  input wire logic [WIDTH-1:0] inData, // Word to store
  output logic outValid, // FIFO holds a word
  input wire logic outReady, // Sink takes the word
  output logic [WIDTH-1:0] outData // Oldest word
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic [PW-1:0] next_wrPtr;
  logic [PW-1:0] next_rdPtr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  // Handshake and pointer arithmetic
  assign inReady = (count != DEPTH[PW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
    next_count = count;
    if (push && !pop) begin
      next_count = (PW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (PW+1)'(count - 1'b1);
    end
  end

  // Pointer and occupancy registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage array, written only on accepted pushes
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// *** logic/spr_serial_port.sv ***
// Serial port register set with address recognition and transmit FIFO
`timescale 1ns/1ps
module spr_serial_port (
  input wire logic clock, // Core clock, 125 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] sfrAddr, // Special-function register address
  input wire logic sfrWr, // Byte write strobe
  input wire logic [7:0] sfrWrData, // Byte write data
  input wire logic sfrRd, // Read strobe
  output logic [7:0] sfrRdData, // Read data, one cycle after strobe
  input wire logic sfrBitSet, // Set one control bit
  input wire logic sfrBitClr, // Clear one control bit
  input wire logic [2:0] sfrBitIdx, // Control bit index for set/clear
  input wire logic framingDetectSelect, // Framing detection enable
  output logic txBufReady, // Transmit FIFO can take a byte
  output logic txValid, // Frame word waiting for the shifter
  input wire logic txReady, // Shifter takes the word
  output logic [7:0] txData, // Byte to send
  output logic txNinth, // Ninth bit to send
  input wire logic txDone, // Pulse: transmit flag point reached
  input wire logic rxDataDone, // Pulse: last data bit received
  input wire logic [7:0] rxData, // Received byte
  input wire logic rxNinth, // Received ninth bit
  input wire logic rxStopDone, // Pulse: stop bit sampled
  input wire logic rxStopValid, // Stop bit level was valid
  output logic [1:0] portMode, // Mode bits to the shifters
  output logic rxEnable, // Receive enable to the shifter
  output logic framingError // Sticky framing error flag
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_WAIT_STOP = 2'b10
  } spr_rx_state_t;

  spr_rx_state_t rxState;
  spr_rx_state_t next_rxState;
  logic [7:0] control;
  logic frameErr;
  logic [7:0] rxBuf;
  logic [7:0] slaveAddress;
  logic [7:0] slaveMask;
  logic [7:0] holdData;
  logic holdNinth;
  logic [7:0] rdData;
  logic [7:0] next_control;
  logic next_frameErr;
  logic [7:0] next_rxBuf;
  logic [7:0] next_slaveAddress;
  logic [7:0] next_slaveMask;
  logic [7:0] next_holdData;
  logic next_holdNinth;
  logic [7:0] next_rdData;
  logic fifoPush;
  logic [8:0] fifoOut;
  logic nineBit;
  logic commit;
  logic [7:0] commitData;
  logic commitNinth;
  logic commitStop;
  logic checkStop;

  // ****************************************************************
  // Address recognition helpers
  // ****************************************************************
  // Given address: masked bits must equal the slave address
  function automatic logic givenMatch(input logic [7:0] d,
                                      input logic [7:0] a,
                                      input logic [7:0] m);
    givenMatch = (((d ^ a) & m) == 8'h00);
  endfunction

  // Broadcast: ones of address OR mask must be ones, zeros don't care
  function automatic logic broadcastMatch(input logic [7:0] d,
                                          input logic [7:0] a,
                                          input logic [7:0] m);
    logic [7:0] bc;
    bc = a | m;
    broadcastMatch = ((d & bc) == bc);
  endfunction

  // Control bit 7 reads as framing error or mode bit zero
  function automatic logic [7:0] controlView(input logic [7:0] c,
                                             input logic f,
                                             input logic sel);
    controlView = {sel ? f : c[spr_pkg::BIT_MODE0_ERR], c[6:0]};
  endfunction

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign portMode = {control[spr_pkg::BIT_MODE0_ERR],
                     control[spr_pkg::BIT_MODE1]};
  assign rxEnable = control[spr_pkg::BIT_RX_ENABLE];
  assign framingError = frameErr;
  assign nineBit = portMode[1];
  assign sfrRdData = rdData;
  assign txData = fifoOut[7:0];
  assign txNinth = fifoOut[8];

  // Data buffer writes queue the byte with the current ninth bit
  assign fifoPush = sfrWr && (sfrAddr == spr_pkg::ADDR_DATA);

  spr_fifo #(
    .WIDTH(spr_pkg::FIFO_WIDTH),
    .DEPTH(spr_pkg::FIFO_DEPTH)
  ) txFifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(fifoPush),
    .inReady(txBufReady),
    .inData({control[spr_pkg::BIT_TX_NINTH], sfrWrData}),
    .outValid(txValid),
    .outReady(txReady),
    .outData(fifoOut)
  );

  // ****************************************************************
  // Receive frame sequencing
  // ****************************************************************
  // Chooses when a frame completes: data bit, or stop bit if checking
  always_comb begin
    next_rxState = rxState;
    next_holdData = holdData;
    next_holdNinth = holdNinth;
    commit = 1'b0;
    commitData = rxData;
    commitNinth = rxNinth;
    commitStop = 1'b1;
    checkStop = 1'b0;
    unique case (rxState)
      RX_IDLE: begin
        if (rxDataDone && rxEnable) begin
          if (framingDetectSelect && portMode != spr_pkg::MODE_SHIFT) begin
            next_holdData = rxData;
            next_holdNinth = rxNinth;
            next_rxState = RX_WAIT_STOP;
          end else begin
            commit = 1'b1;
          end
        end
      end
      RX_WAIT_STOP: begin
        if (rxDataDone) begin
          next_holdData = rxData;
          next_holdNinth = rxNinth;
        end else if (rxStopDone) begin
          commit = 1'b1;
          checkStop = 1'b1;
          commitData = holdData;
          commitNinth = holdNinth;
          commitStop = rxStopValid;
          next_rxState = RX_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Register file next values
  // ****************************************************************
  // Software writes first, hardware events after so a set wins
  always_comb begin
    logic accept;
    logic addrOk;
    accept = 1'b0;
    addrOk = 1'b0;
    next_control = control;
    next_frameErr = frameErr;
    next_rxBuf = rxBuf;
    next_slaveAddress = slaveAddress;
    next_slaveMask = slaveMask;
    // Byte writes
    if (sfrWr) begin
      unique case (sfrAddr)
        spr_pkg::ADDR_CONTROL: begin
          next_control[6:0] = sfrWrData[6:0];
          if (framingDetectSelect) begin
            next_frameErr = sfrWrData[7];
          end else begin
            next_control[spr_pkg::BIT_MODE0_ERR] = sfrWrData[7];
          end
        end
        spr_pkg::ADDR_SLAVE: next_slaveAddress = sfrWrData;
        spr_pkg::ADDR_MASK: next_slaveMask = sfrWrData;
        default: ;
      endcase
    end
    // Single-bit set and clear on the control register
    if (sfrBitSet || sfrBitClr) begin
      if (sfrBitIdx == 3'h7 && framingDetectSelect) begin
        next_frameErr = sfrBitSet;
      end else begin
        next_control[sfrBitIdx] = sfrBitSet;
      end
    end
    // Transmit flag from the shifter
    if (txDone) begin
      next_control[spr_pkg::BIT_TX_DONE] = 1'b1;
    end
    // Framing check on the stop bit
    if (checkStop && !commitStop) begin
      next_frameErr = 1'b1;
    end
    // Frame acceptance: free buffer, multiprocessor filter
    addrOk = givenMatch(commitData, slaveAddress, slaveMask) ||
             broadcastMatch(commitData, slaveAddress, slaveMask);
    if (commit && !control[spr_pkg::BIT_RX_DONE]) begin
      if (!control[spr_pkg::BIT_MULTIPROC]) begin
        accept = 1'b1;
      end else if (nineBit) begin
        accept = commitNinth && addrOk;
      end else begin
        accept = commitStop;
      end
    end
    if (accept) begin
      next_rxBuf = commitData;
      next_control[spr_pkg::BIT_RX_DONE] = 1'b1;
      if (nineBit) begin
        next_control[spr_pkg::BIT_RX_NINTH] = commitNinth;
      end
    end
  end

  // Registered read data, unmapped addresses read zero
  always_comb begin
    next_rdData = rdData;
    if (sfrRd) begin
      unique case (sfrAddr)
        spr_pkg::ADDR_CONTROL:
          next_rdData = controlView(control, frameErr, framingDetectSelect);
        spr_pkg::ADDR_DATA: next_rdData = rxBuf;
        spr_pkg::ADDR_SLAVE: next_rdData = slaveAddress;
        spr_pkg::ADDR_MASK: next_rdData = slaveMask;
        default: next_rdData = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      control <= spr_pkg::RST_CONTROL;
      frameErr <= 1'b0;
      rxBuf <= spr_pkg::RST_DATA;
      slaveAddress <= spr_pkg::RST_SLAVE;
      slaveMask <= spr_pkg::RST_MASK;
      holdData <= 8'h00;
      holdNinth <= 1'b0;
      rdData <= 8'h00;
    end else begin
      rxState <= next_rxState;
      control <= next_control;
      frameErr <= next_frameErr;
      rxBuf <= next_rxBuf;
      slaveAddress <= next_slaveAddress;
      slaveMask <= next_slaveMask;
      holdData <= next_holdData;
      holdNinth <= next_holdNinth;
      rdData <= next_rdData;
    end
  end
endmodule

// *** verif/spr_serial_port_chk.sv ***
// Assertion checker for the serial port register set
`timescale 1ns/1ps
module spr_chk (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] sfrAddr, // Register address
  input wire logic sfrWr, // Write strobe
  input wire logic [7:0] sfrWrData, // Write data
  input wire logic sfrRd, // Read strobe
  input wire logic [7:0] sfrRdData, // Read data
  input wire logic sfrBitSet, // Bit set strobe
  input wire logic sfrBitClr, // Bit clear strobe
  input wire logic [2:0] sfrBitIdx, // Bit index
  input wire logic framingDetectSelect, // Framing detection enable
  input wire logic txValid, // FIFO head valid
  input wire logic txReady, // Shifter takes head
  input wire logic [7:0] txData, // FIFO head byte
  input wire logic rxDataDone, // Data bits done
  input wire logic rxStopDone, // Stop bit sampled
  input wire logic rxStopValid, // Stop bit level
  input wire logic [1:0] portMode, // Mode bits
  input wire logic rxEnable, // Receive enable
  input wire logic framingError // Sticky framing error
);
  logic [7:0] maskSeen;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Last value written to the mask register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      maskSeen <= 8'h00;
    end else if (sfrWr && sfrAddr == 8'hB9) begin
      maskSeen <= sfrWrData;
    end
  end
  // Frame taken with framing detection, then a bad stop bit
  sequence s_frame;
    rxDataDone && rxEnable && framingDetectSelect && portMode != 2'h0;
  endsequence
  sequence s_badStop;
    rxStopDone && !rxStopValid && !rxDataDone;
  endsequence
  a_unmapped_read: assert property (
    sfrRd && !(sfrAddr inside {8'h98, 8'h99, 8'hA9, 8'hB9})
    |=> sfrRdData == 8'h00) else $error("unmapped read not zero");
  a_mode_write: assert property (
    sfrWr && sfrAddr == 8'h98 && !framingDetectSelect &&
    !sfrBitSet && !sfrBitClr
    |=> portMode == $past(sfrWrData[7:6])) else $error("mode bits wrong");
  a_bit_set: assert property (
    sfrBitSet && sfrBitIdx == 3'h4 |=> rxEnable)
    else $error("bit set lost");
  a_bit_clear: assert property (
    sfrBitClr && !sfrBitSet && sfrBitIdx == 3'h4 |=> !rxEnable)
    else $error("bit clear lost");
  a_err_sticky: assert property (
    framingError && !sfrBitClr && !(sfrWr && sfrAddr == 8'h98)
    |=> framingError) else $error("framing error dropped");
  a_err_on_stop: assert property (
    s_frame ##[1:8] s_badStop |=> framingError)
    else $error("framing error not set");
  a_mask_read: assert property (
    sfrRd && !sfrWr && sfrAddr == 8'hB9 |=> sfrRdData == maskSeen)
    else $error("mask read wrong");
  a_tx_push: assert property (
    sfrWr && sfrAddr == 8'h99 && !txValid
    |=> txValid && txData == $past(sfrWrData)) else $error("push lost");
  a_tx_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("head changed while stalled");
endmodule
bind spr_serial_port spr_chk chk (
  .clock(clock),
  .rst_n(rst_n),
  .sfrAddr(sfrAddr),
  .sfrWr(sfrWr),
  .sfrWrData(sfrWrData),
  .sfrRd(sfrRd),
  .sfrRdData(sfrRdData),
  .sfrBitSet(sfrBitSet),
  .sfrBitClr(sfrBitClr),
  .sfrBitIdx(sfrBitIdx),
  .framingDetectSelect(framingDetectSelect),
  .txValid(txValid),
  .txReady(txReady),
  .txData(txData),
  .rxDataDone(rxDataDone),
  .rxStopDone(rxStopDone),
  .rxStopValid(rxStopValid),
  .portMode(portMode),
  .rxEnable(rxEnable),
  .framingError(framingError)
);

// *** verif/spr_remote_dev.sv ***
// Far side model: transmit shifter sink and receive frame source
`timescale 1ns/1ps
module spr_remote_dev (
  input wire logic clock, // Core clock
  input wire logic stall, // Hold off taking words
  input wire logic txValid, // Word offered
  output logic txReady, // Word taken
  output logic txDone, // Transmit point pulse
  output logic rxDataDone, // Data bits done
  output logic [7:0] rxData, // Received byte
  output logic rxNinth, // Received ninth bit
  output logic rxStopDone, // Stop bit sampled
  output logic rxStopValid // Stop bit level
);
  logic pop;
  // Quiet outputs at start
  initial begin
    txReady = 1'b0;
    txDone = 1'b0;
    rxDataDone = 1'b0;
    rxData = 8'h00;
    rxNinth = 1'b0;
    rxStopDone = 1'b0;
    rxStopValid = 1'b1;
  end
  // Take words unless stalled, pulse done per word
  always @(posedge clock) begin
    pop = txValid && txReady;
    #1;
    txReady = !stall;
    txDone = pop;
  end
  // One frame; released lines show the inverse value
  task automatic send(input logic [7:0] b, input logic n, input logic ok);
    @(posedge clock) #1;
    rxDataDone = 1'b1;
    rxData = b;
    rxNinth = n;
    @(posedge clock) #1;
    rxDataDone = 1'b0;
    rxData = ~b;
    rxNinth = ~n;
    repeat (5) @(posedge clock);
    #1;
    rxStopDone = 1'b1;
    rxStopValid = ok;
    @(posedge clock) #1;
    rxStopDone = 1'b0;
    rxStopValid = ~ok;
  endtask
endmodule

// *** verif/test_spr_serial_port.sv ***
// Testbench for the serial port register set
`timescale 1ns/1ps
module test_spr_serial_port;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic sfrBitSet = 1'b0;
  logic sfrBitClr = 1'b0;
  logic [2:0] sfrBitIdx = 3'h0;
  logic framingDetectSelect = 1'b0;
  logic stall = 1'b0;
  logic [7:0] sfrRdData, txData, rxData, v, a, m, d, lastRx;
  logic txBufReady, txValid, txReady, txNinth, txDone, rxEnable, ok;
  logic rxDataDone, rxNinth, rxStopDone, rxStopValid, framingError;
  logic [1:0] portMode;
  logic [31:0] seed = 32'h00003290;
  logic [8:0] expQ[$];
  logic [7:0] regs[5] = '{8'h98, 8'h99, 8'hA9, 8'hB9, 8'h9A};
  logic [7:0] dl[3] = '{8'hFB, 8'hF0, 8'hF3};
  int mismatches = 0;
  int checks_done = 0;

  always #4 clock = ~clock;
  spr_serial_port uut (
    .clock(clock),
    .rst_n(rst_n),
    .sfrAddr(sfrAddr),
    .sfrWr(sfrWr),
    .sfrWrData(sfrWrData),
    .sfrRd(sfrRd),
    .sfrRdData(sfrRdData),
    .sfrBitSet(sfrBitSet),
    .sfrBitClr(sfrBitClr),
    .sfrBitIdx(sfrBitIdx),
    .framingDetectSelect(framingDetectSelect),
    .txBufReady(txBufReady),
    .txValid(txValid),
    .txReady(txReady),
    .txData(txData),
    .txNinth(txNinth),
    .txDone(txDone),
    .rxDataDone(rxDataDone),
    .rxData(rxData),
    .rxNinth(rxNinth),
    .rxStopDone(rxStopDone),
    .rxStopValid(rxStopValid),
    .portMode(portMode),
    .rxEnable(rxEnable),
    .framingError(framingError)
  );
  spr_remote_dev dev (
    .clock(clock),
    .stall(stall),
    .txValid(txValid),
    .txReady(txReady),
    .txDone(txDone),
    .rxDataDone(rxDataDone),
    .rxData(rxData),
    .rxNinth(rxNinth),
    .rxStopDone(rxStopDone),
    .rxStopValid(rxStopValid)
  );

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Given or broadcast address match
  function automatic logic hits(input logic [7:0] dv, av, mv);
    return (((dv ^ av) & mv) == 8'h00) || ((dv & (av | mv)) == (av | mv));
  endfunction
  task automatic rnd(output logic [7:0] r);
    seed = next_rand(seed);
    r = seed[7:0];
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One register access; read data lands in v
  task automatic bus(input logic [7:0] ad, wd, input logic w);
    @(posedge clock) #1;
    sfrAddr = ad;
    sfrWrData = wd;
    sfrWr = w;
    sfrRd = !w;
    @(posedge clock) #1;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    v = sfrRdData;
  endtask
  task automatic bitop(input logic [2:0] i, input logic s);
    @(posedge clock) #1;
    sfrBitIdx = i;
    sfrBitSet = s;
    sfrBitClr = !s;
    @(posedge clock) #1;
    sfrBitSet = 1'b0;
    sfrBitClr = 1'b0;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Each word taken by the far side matches the queue
  always @(negedge clock) begin
    if (rst_n && txValid && txReady) begin
      chk({txNinth, txData}, expQ.pop_front());
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (regs[i]) begin
      bus(regs[i], 8'h00, 1'b0);
      chk(v, 8'h00);
    end
    repeat (6) begin
      rnd(a);
      rnd(m);
      bus(8'hA9, a, 1'b1);
      bus(8'hB9, m, 1'b1);
      bus(8'hA9, 8'h00, 1'b0);
      chk(v, a);
      bus(8'hB9, 8'h00, 1'b0);
      chk(v, m);
    end
    for (int i = 0; i < 8; i++) begin
      bitop(i[2:0], 1'b1);
      bus(8'h98, 8'h00, 1'b0);
      chk(v, 9'h001 << i);
      bitop(i[2:0], 1'b0);
      bus(8'h98, 8'h00, 1'b0);
      chk(v, 8'h00);
    end
    // Fill the stalled FIFO past full, then drain it
    stall = 1'b1;
    bitop(3'h3, 1'b1);
    for (int k = 0; k < 17; k++) begin
      rnd(d);
      if (k < 16) expQ.push_back({1'b1, d});
      bus(8'h99, d, 1'b1);
    end
    chk(txBufReady, 1'b0);
    stall = 1'b0;
    for (int k = 0; k < 100 && txValid !== 1'b0; k++) @(posedge clock) #1;
    if (txValid !== 1'b0) begin
      mismatches++;
      end_sim();
    end
    chk(9'(expQ.size()), 9'h000);
    bus(8'h98, 8'h00, 1'b0);
    chk(v, 8'h0A);
    bitop(3'h1, 1'b0);
    bus(8'h98, 8'h00, 1'b0);
    chk(v, 8'h08);
    // Framing detection: flag waits for a bad stop bit
    bus(8'h98, 8'hD0, 1'b1);
    framingDetectSelect = 1'b1;
    fork
      dev.send(8'h5A, 1'b1, 1'b0);
      begin
        repeat (3) @(posedge clock);
        bus(8'h98, 8'h00, 1'b0);
        chk(v, 8'h50);
      end
    join
    bus(8'h98, 8'h00, 1'b0);
    chk(v, 8'hD5);
    bus(8'h99, 8'h00, 1'b0);
    chk(v, 8'h5A);
    bitop(3'h0, 1'b0);
    dev.send(8'hA5, 1'b0, 1'b1);
    bus(8'h98, 8'h00, 1'b0);
    chk(v, 8'hD1);
    bitop(3'h7, 1'b0);
    chk(framingError, 1'b0);
    // Multiprocessor address recognition
    framingDetectSelect = 1'b0;
    bus(8'h98, 8'hF0, 1'b1);
    lastRx = 8'hA5;
    for (int k = 0; k < 10; k++) begin
      rnd(a);
      rnd(m);
      rnd(d);
      if (k < 3) {a, m, d} = {8'hF1, 8'hFA, dl[k]};
      else if (k[0]) d = a ^ (~m & d);
      bus(8'hA9, a, 1'b1);
      bus(8'hB9, m, 1'b1);
      dev.send(d, 1'b1, 1'b1);
      ok = hits(d, a, m);
      if (ok) lastRx = d;
      bus(8'h98, 8'h00, 1'b0);
      chk(v & 8'hFB, {7'h78, ok});
      bus(8'h99, 8'h00, 1'b0);
      chk(v, lastRx);
      bitop(3'h0, 1'b0);
    end
    end_sim();
  end
endmodule
